//--- hdl/otp_seq_pkg.sv
// Function
// - Read command copies one or all source pages into the shadow RAM.
// - Memory select 1 reads the OTP array, 0 reads the external EEPROM.
// - Margin level reaches the OTP only; EEPROM reads ignore it.
// - Page field picks one page; bulk bit picks all pages.
// - Write command programs OTP pages from shadow RAM; OTP only.
// - OTP writes reach only pages 2 and 3; bulk writes those two.
// - Bulk OTP write raises the fail flag; software clears it first.
// - Verify compares OTP with shadow RAM; any difference sets fail.
// - Finalise marks OTP only; software copies final bit to shadow RAM.
// - After finalise, OTP writes to pages 2 and 3 have no effect.
// - Customer final bit sits in page 2, code 10; locks pages 2, 3.
// - Write, verify and finalise are not supported on the EEPROM.
// - OTP codes select pages 0-3; EEPROM codes select 2-4, 11 reserved.
// - Control layout: 15 prog, 13 mem, 11-8 commands, 7:6 margin, 5 bulk.
// - Command end flag rises each time a command completes.
// - Fail flag rises on EEPROM read fail, mismatch, bulk, locked or factory-page write, or EEPROM read of code 11.
package otp_seq_pkg;
   // Control word layout
   localparam int CTRL_W = 16;
   localparam int PROG_BIT = 15;
   localparam int MEM_BIT = 13;
   localparam int FINAL_BIT = 11;
   localparam int VERIFY_BIT = 10;
   localparam int WRITE_BIT = 9;
   localparam int READ_BIT = 8;
   localparam int MARGIN_HI = 7;
   localparam int MARGIN_LO = 6;
   localparam int BULK_BIT = 5;
   localparam int PAGE_HI = 1;
   localparam int PAGE_LO = 0;
   // Memory geometry
   localparam int WORD_W = 8;
   localparam int WORD_IDX_W = 3;
   localparam int PAGE_IDX_W = 3;
   localparam int ADDR_W = PAGE_IDX_W + WORD_IDX_W;
   localparam logic [WORD_IDX_W-1:0] LAST_WORD = 3'h7;
   localparam logic [WORD_IDX_W-1:0] FIRST_WORD = 3'h0;
   // Page numbering, in shadow RAM page numbers
   localparam logic [PAGE_IDX_W-1:0] OTP_FIRST_PAGE = 3'h0;
   localparam logic [PAGE_IDX_W-1:0] OTP_LAST_PAGE = 3'h3;
   localparam logic [PAGE_IDX_W-1:0] USER_FIRST_PAGE = 3'h2;
   localparam logic [PAGE_IDX_W-1:0] USER_LAST_PAGE = 3'h3;
   localparam logic [PAGE_IDX_W-1:0] EEPROM_PAGE_BASE = 3'h2;
   localparam logic [PAGE_IDX_W-1:0] EEPROM_LAST_PAGE = 3'h4;
   localparam logic [1:0] EEPROM_RSVD_CODE = 2'h3;
   localparam logic [1:0] FINAL_PAGE_CODE = 2'h2;
   localparam logic [1:0] MARGIN_NORMAL = 2'h0;
   // Reset values
   localparam logic [1:0] MARGIN_RESET = 2'h0;
   localparam logic [WORD_W-1:0] DATA_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

   typedef enum logic [1:0] {
      CMD_READ = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_VERIFY = 2'h2,
      CMD_FINAL = 2'h3
   } cmd_e;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SETUP = 6'h02,
      ST_ISSUE = 6'h04,
      ST_REQ = 6'h08,
      ST_DATA = 6'h10,
      ST_NEXT = 6'h20
   } seq_state_e;
endpackage : otp_seq_pkg

//--- hdl/page_range_decode.sv
`timescale 1ns/1ns
// Turns memory select, bulk and page code into a page span
module page_range_decode
   import otp_seq_pkg::*;
(
   // Command fields
   input wire logic otpSel,
   input wire logic bulk,
   input wire logic [1:0] pageCode,
   input wire logic isWrite,
   // Span in shadow RAM page numbers
   output logic [PAGE_IDX_W-1:0] firstPage,
   output logic [PAGE_IDX_W-1:0] lastPage,
   output logic rangeOk,
   output logic bulkWriteErr
);
   // Page mapping differs by memory; EEPROM sits above the factory pages
   always_comb begin
      firstPage = OTP_FIRST_PAGE;
      lastPage = OTP_LAST_PAGE;
      rangeOk = 1'b1;
      bulkWriteErr = 1'b0;
      if (otpSel) begin
         if (bulk && isWrite) begin
            firstPage = USER_FIRST_PAGE;
            lastPage = USER_LAST_PAGE;
            bulkWriteErr = 1'b1;
         end else if (!bulk) begin
            firstPage = {1'b0, pageCode};
            lastPage = {1'b0, pageCode};
            // Factory pages are never programmed by a single write
            rangeOk = !isWrite || ({1'b0, pageCode} >= USER_FIRST_PAGE);
         end
      end else begin
         if (bulk) begin
            firstPage = EEPROM_PAGE_BASE;
            lastPage = EEPROM_LAST_PAGE;
         end else begin
            firstPage = EEPROM_PAGE_BASE + {1'b0, pageCode};
            lastPage = EEPROM_PAGE_BASE + {1'b0, pageCode};
            rangeOk = (pageCode != EEPROM_RSVD_CODE);
         end
      end
   end
endmodule : page_range_decode

//--- hdl/otp_eeprom_command_sequencer.sv
`timescale 1ns/1ns
module otp_eeprom_command_sequencer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control word write from software
   input wire logic ctrlWrite,
   input wire logic [otp_seq_pkg::CTRL_W-1:0] ctrlWord,
   // Event flags, one-cycle clear pulses
   input wire logic commandEndClear,
   input wire logic commandFailClear,
   output logic commandEndFlag,
   output logic commandFailFlag,
   output logic busy,
   // Config shadow RAM, read data one cycle after the read strobe
   output logic [otp_seq_pkg::ADDR_W-1:0] shadowAddr,
   output logic shadowRdEn,
   output logic shadowWrEn,
   output logic [otp_seq_pkg::WORD_W-1:0] shadowWrData,
   input wire logic [otp_seq_pkg::WORD_W-1:0] shadowRdData,
   // OTP array, read data one cycle after the read strobe
   output logic [otp_seq_pkg::ADDR_W-1:0] otpAddr,
   output logic otpRdEn,
   output logic otpProgEn,
   output logic [otp_seq_pkg::WORD_W-1:0] otpProgData,
   output logic [1:0] otpMargin,
   output logic otpFinalPulse,
   input wire logic [otp_seq_pkg::WORD_W-1:0] otpRdData,
   input wire logic otpFinalIn,
   // External config EEPROM, request held until acknowledge
   output logic [otp_seq_pkg::ADDR_W-1:0] eepromAddr,
   output logic eepromRdReq,
   input wire logic eepromAck,
   input wire logic eepromErr,
   input wire logic [otp_seq_pkg::WORD_W-1:0] eepromRdData
);
   import otp_seq_pkg::*;

   seq_state_e state_r;
   cmd_e cmd_r;
   logic cmdValid;
   cmd_e cmdDecoded;
   logic otpSel_r, bulk_r;
   logic [1:0] pageCode_r, margin_r;
   logic [PAGE_IDX_W-1:0] curPage_r, lastPage_r;
   logic [WORD_IDX_W-1:0] word_r;
   logic [PAGE_IDX_W-1:0] firstPage, lastPage;
   logic rangeOk, bulkWriteErr;
   logic finalLocked_r, lockAtStart_r;
   logic [WORD_W-1:0] eepromHold_r;
   logic setFail, setEnd, mismatch, lockedWrite, unsupported;
   logic [ADDR_W-1:0] curAddr;
   logic [WORD_W-1:0] srcData;

   // Exactly one command bit; several or none means no command at all
   always_comb begin
      cmdValid = 1'b1;
      cmdDecoded = CMD_READ;
      unique case ({ctrlWord[FINAL_BIT], ctrlWord[VERIFY_BIT],
                    ctrlWord[WRITE_BIT], ctrlWord[READ_BIT]})
         4'h1: cmdDecoded = CMD_READ;
         4'h2: cmdDecoded = CMD_WRITE;
         4'h4: cmdDecoded = CMD_VERIFY;
         4'h8: cmdDecoded = CMD_FINAL;
         default: cmdValid = 1'b0;
      endcase
   end

   page_range_decode u_range (
      .otpSel(otpSel_r),
      .bulk(bulk_r),
      .pageCode(pageCode_r),
      .isWrite(cmd_r == CMD_WRITE),
      .firstPage(firstPage),
      .lastPage(lastPage),
      .rangeOk(rangeOk),
      .bulkWriteErr(bulkWriteErr)
   );

   assign curAddr = {curPage_r, word_r};
   // Locked pages are the user pages once the customer final bit is set
   // EEPROM writes are unsupported and end silently, so they never count
   assign lockedWrite = lockAtStart_r && otpSel_r
                        && (cmd_r == CMD_WRITE);
   assign unsupported = !otpSel_r && (cmd_r != CMD_READ);
   // EEPROM data is parked at acknowledge since the part drops it after
   assign srcData = otpSel_r ? otpRdData : eepromHold_r;
   assign mismatch = (state_r == ST_DATA) && (cmd_r == CMD_VERIFY)
                     && (otpRdData != shadowRdData);
   assign setEnd = (state_r == ST_NEXT) && (word_r == LAST_WORD)
                   && (curPage_r == lastPage_r);

   // Fail sources gathered in one place so the flag has a single driver
   always_comb begin
      setFail = 1'b0;
      if (state_r == ST_SETUP && (bulkWriteErr || lockedWrite)) begin
         setFail = 1'b1;
      end
      if (state_r == ST_REQ && !otpSel_r && eepromAck && eepromErr) begin
         setFail = 1'b1;
      end
      if (mismatch) begin
         setFail = 1'b1;
      end
      if (state_r == ST_SETUP && !rangeOk && !unsupported) begin
         setFail = 1'b1;
      end
   end

   // Sequencer; short-cut endings jump to NEXT on the last word
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (ctrlWrite && cmdValid) begin
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cmd_r == CMD_FINAL || unsupported || !rangeOk
                   || lockedWrite) begin
                  state_r <= ST_NEXT;
               end else begin
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: state_r <= ST_REQ;
            ST_REQ: begin
               if (otpSel_r || eepromAck) begin
                  state_r <= (eepromAck && eepromErr) ? ST_NEXT : ST_DATA;
               end
            end
            ST_DATA: state_r <= ST_NEXT;
            ST_NEXT: begin
               if (setEnd) begin
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_ISSUE;
               end
            end
         endcase
      end
   end

   // Command capture only when idle, so busy writes are simply dropped
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cmd_r <= CMD_READ;
         otpSel_r <= 1'b1;
         bulk_r <= 1'b0;
         pageCode_r <= 2'h0;
         margin_r <= MARGIN_RESET;
         lockAtStart_r <= 1'b0;
      end else if (state_r == ST_IDLE && ctrlWrite && cmdValid) begin
         cmd_r <= cmdDecoded;
         otpSel_r <= ctrlWord[MEM_BIT];
         bulk_r <= ctrlWord[BULK_BIT];
         pageCode_r <= ctrlWord[PAGE_HI:PAGE_LO];
         margin_r <= ctrlWord[MARGIN_HI:MARGIN_LO];
         lockAtStart_r <= finalLocked_r || otpFinalIn;
      end
   end

   // Page and word walk; early endings park the walk on the last word
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         curPage_r <= OTP_FIRST_PAGE;
         lastPage_r <= OTP_FIRST_PAGE;
         word_r <= FIRST_WORD;
      end else if (state_r == ST_SETUP) begin
         curPage_r <= firstPage;
         lastPage_r <= firstPage;
         word_r <= LAST_WORD;
         if (!(cmd_r == CMD_FINAL || unsupported || !rangeOk
               || lockedWrite)) begin
            lastPage_r <= lastPage;
            word_r <= FIRST_WORD;
         end
      end else if (state_r == ST_REQ && eepromAck && eepromErr) begin
         lastPage_r <= curPage_r; // Abort the read on a transfer failure
         word_r <= LAST_WORD;
      end else if (state_r == ST_NEXT && !setEnd) begin
         if (word_r == LAST_WORD) begin
            curPage_r <= curPage_r + 3'h1;
            word_r <= FIRST_WORD;
         end else begin
            word_r <= word_r + 3'h1;
         end
      end
   end

   // Memory strobes; each lasts one cycle except the EEPROM request
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         shadowRdEn <= 1'b0;
         shadowWrEn <= 1'b0;
         otpRdEn <= 1'b0;
         otpProgEn <= 1'b0;
         eepromRdReq <= 1'b0;
         shadowAddr <= ADDR_RESET;
         otpAddr <= ADDR_RESET;
         eepromAddr <= ADDR_RESET;
         shadowWrData <= DATA_RESET;
         otpProgData <= DATA_RESET;
         eepromHold_r <= DATA_RESET;
      end else begin
         shadowRdEn <= 1'b0;
         shadowWrEn <= 1'b0;
         otpRdEn <= 1'b0;
         otpProgEn <= 1'b0;
         if (state_r == ST_ISSUE) begin
            shadowAddr <= curAddr;
            shadowRdEn <= (cmd_r != CMD_READ);
            if (otpSel_r) begin
               otpAddr <= curAddr;
               otpRdEn <= (cmd_r != CMD_WRITE);
            end else begin
               eepromAddr <= curAddr;
               eepromRdReq <= 1'b1;
            end
         end
         if (state_r == ST_REQ && eepromAck) begin
            eepromRdReq <= 1'b0;
            eepromHold_r <= eepromRdData;
         end
         if (state_r == ST_DATA && cmd_r == CMD_READ) begin
            shadowWrEn <= 1'b1;
            shadowWrData <= srcData;
         end
         if (state_r == ST_DATA && cmd_r == CMD_WRITE && otpSel_r
             && !lockAtStart_r) begin
            otpProgEn <= 1'b1;
            otpProgData <= shadowRdData;
         end
      end
   end

   // Margin is forced to normal for anything but an OTP operation
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         otpMargin <= MARGIN_RESET;
      end else if (state_r != ST_IDLE && otpSel_r) begin
         otpMargin <= margin_r;
      end else begin
         otpMargin <= MARGIN_NORMAL;
      end
   end

   // Finalise: only page code 10 on the OTP sets the lock
   // The shadow RAM is left untouched; software copies the bit itself
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         otpFinalPulse <= 1'b0;
         finalLocked_r <= 1'b0;
      end else begin
         otpFinalPulse <= 1'b0;
         if (state_r == ST_SETUP && cmd_r == CMD_FINAL && otpSel_r
             && !bulk_r && pageCode_r == FINAL_PAGE_CODE) begin
            otpFinalPulse <= 1'b1;
            finalLocked_r <= 1'b1;
         end
      end
   end

   // Sticky flags; a set in the clearing cycle wins so no event is lost
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         commandEndFlag <= 1'b0;
         commandFailFlag <= 1'b0;
         busy <= 1'b0;
      end else begin
         commandEndFlag <= setEnd || (commandEndFlag && !commandEndClear);
         commandFailFlag <= setFail
                            || (commandFailFlag && !commandFailClear);
         busy <= (state_r == ST_IDLE) ? (ctrlWrite && cmdValid) : !setEnd;
      end
   end

   busy_ignore_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_r != ST_IDLE && ctrlWrite) |=> (cmd_r == $past(cmd_r)))
      else $error("command changed while busy");
   end_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
      setEnd |=> commandEndFlag && busy == 1'b0)
      else $error("end flag missing after completion");
   margin_mem_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_r == ST_REQ && !otpSel_r) |-> otpMargin == MARGIN_NORMAL)
      else $error("margin applied to EEPROM");
   lock_prog_a: assert property (@(posedge sys_clk) disable iff (reset)
      otpProgEn |-> !lockAtStart_r && !$past(finalLocked_r, 2))
      else $error("program after finalise");
   prog_pages_a: assert property (@(posedge sys_clk) disable iff (reset)
      otpProgEn |-> otpAddr[ADDR_W-1:WORD_IDX_W] >= USER_FIRST_PAGE
                    && otpAddr[ADDR_W-1:WORD_IDX_W] <= USER_LAST_PAGE)
      else $error("program outside user pages");
   prog_otp_a: assert property (@(posedge sys_clk) disable iff (reset)
      (otpProgEn || otpFinalPulse) |-> otpSel_r && !eepromRdReq)
      else $error("OTP-only command on EEPROM");
   verify_fail_a: assert property (@(posedge sys_clk) disable iff (reset)
      mismatch |=> commandFailFlag)
      else $error("verify mismatch not flagged");
   read_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_r == ST_DATA && cmd_r == CMD_READ) |=>
      shadowWrEn && shadowAddr == $past(curAddr, 3))
      else $error("read word not copied");
   bulk_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_r == ST_SETUP && cmd_r == CMD_WRITE && bulk_r && otpSel_r)
      |=> commandFailFlag)
      else $error("bulk write did not flag");
   eeprom_map_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(eepromRdReq) |-> !otpSel_r
      && eepromAddr[ADDR_W-1:WORD_IDX_W] >= EEPROM_PAGE_BASE
      && eepromAddr[ADDR_W-1:WORD_IDX_W] <= EEPROM_LAST_PAGE)
      else $error("EEPROM page out of map");
   final_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
      otpFinalPulse |-> finalLocked_r ##[1:3] commandEndFlag)
      else $error("finalise did not lock");
endmodule : otp_eeprom_command_sequencer

//--- tb/nv_partner.sv
`timescale 1ns/1ns
// Stand-in for shadow RAM, OTP array and EEPROM around the sequencer
module nv_partner
   import otp_seq_pkg::*;
#(
   parameter logic [otp_seq_pkg::ADDR_W-1:0] FINAL_ADDR = 6'h10,
   parameter logic [otp_seq_pkg::WORD_W-1:0] FINAL_MASK = 8'h01
) (
   // Clock and fault request
   input wire logic sys_clk,
   input wire logic failReq,
   // Shadow RAM
   input wire logic [otp_seq_pkg::ADDR_W-1:0] shadowAddr,
   input wire logic shadowRdEn,
   input wire logic shadowWrEn,
   input wire logic [otp_seq_pkg::WORD_W-1:0] shadowWrData,
   output logic [otp_seq_pkg::WORD_W-1:0] shadowRdData,
   // OTP array
   input wire logic [otp_seq_pkg::ADDR_W-1:0] otpAddr,
   input wire logic otpRdEn,
   input wire logic otpProgEn,
   input wire logic [otp_seq_pkg::WORD_W-1:0] otpProgData,
   input wire logic otpFinalPulse,
   output logic [otp_seq_pkg::WORD_W-1:0] otpRdData,
   output logic otpFinalIn,
   // External EEPROM
   input wire logic [otp_seq_pkg::ADDR_W-1:0] eepromAddr,
   input wire logic eepromRdReq,
   output logic eepromAck,
   output logic eepromErr,
   output logic [otp_seq_pkg::WORD_W-1:0] eepromRdData
);
   logic [WORD_W-1:0] shadowMem [64];
   logic [WORD_W-1:0] otpMem [64];
   logic [WORD_W-1:0] eepMem [64];
   logic [2:0] eepCnt;
   // Distinct patterns so each source can be told apart
   initial begin
      for (int i = 0; i < 64; i++) begin
         shadowMem[i] = 8'h00;
         otpMem[i] = 8'h40 + 8'(i);
         eepMem[i] = 8'h80 + 8'(i);
      end
      {shadowRdData, otpRdData, eepromRdData} = 24'h000000;
      {otpFinalIn, eepromAck, eepromErr, eepCnt} = 6'h00;
   end
   // Read data is valid one cycle only; otherwise it toggles
   always @(posedge sys_clk) begin
      shadowRdData <= ~shadowRdData;
      if (shadowRdEn) shadowRdData <= shadowMem[shadowAddr];
      if (shadowWrEn) shadowMem[shadowAddr] <= shadowWrData;
   end
   // Fuses modelled as a plain overwrite; locking is left to the design
   always @(posedge sys_clk) begin
      otpRdData <= ~otpRdData;
      if (otpRdEn) otpRdData <= otpMem[otpAddr];
      if (otpProgEn) otpMem[otpAddr] <= otpProgData;
      // Finalise marks the OTP copy only, never the shadow RAM
      if (otpFinalPulse) begin
         otpMem[FINAL_ADDR] <= otpMem[FINAL_ADDR] | FINAL_MASK;
         otpFinalIn <= 1'b1;
      end
   end
   // Odd words answer slowly, even words at once
   always @(posedge sys_clk) begin
      eepromAck <= 1'b0;
      eepromErr <= 1'b0;
      eepromRdData <= ~eepromRdData;
      if (eepromRdReq && !eepromAck) begin
         if (eepCnt == (eepromAddr[0] ? 3'h5 : 3'h0)) begin
            eepromAck <= 1'b1;
            eepromErr <= failReq;
            eepromRdData <= eepMem[eepromAddr];
            eepCnt <= 3'h0;
         end else begin
            eepCnt <= eepCnt + 3'h1;
         end
      end
   end
endmodule : nv_partner

//--- tb/test_otp_eeprom_command_sequencer.sv
`timescale 1ns/1ns
`define CHK(what, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
module test_otp_eeprom_command_sequencer;
   import otp_seq_pkg::*;
   typedef struct {logic [15:0] word; logic fail;} row_s;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic ctrlWrite = 1'b0;
   logic [CTRL_W-1:0] ctrlWord = 16'h0000;
   logic commandEndClear = 1'b0;
   logic commandFailClear = 1'b0;
   logic commandEndFlag, commandFailFlag, busy;
   logic [ADDR_W-1:0] shadowAddr, otpAddr, eepromAddr;
   logic shadowRdEn, shadowWrEn, otpRdEn, otpProgEn, otpFinalPulse;
   logic [WORD_W-1:0] shadowWrData, shadowRdData, otpProgData;
   logic [WORD_W-1:0] otpRdData, eepromRdData;
   logic [1:0] otpMargin;
   logic otpFinalIn, eepromRdReq, eepromAck, eepromErr;
   logic failReq = 1'b0;
   logic [1:0] marginSeen = 2'h0;
   logic marginBad = 1'b0;
   int n_errors = 0;
   int n_tests = 0;
   int progCount = 0;
   int finalCount = 0;
   int p;
   // Ordinary commands with the fail flag each should leave
   row_s rows [18] = '{'{16'h0120, 1'b0}, '{16'h2120, 1'b0},
      '{16'h2480, 1'b0}, '{16'h2481, 1'b0}, '{16'h2482, 1'b0},
      '{16'h2483, 1'b0}, '{16'h24A0, 1'b0}, '{16'h2200, 1'b1},
      '{16'h2201, 1'b1}, '{16'h2202, 1'b0}, '{16'h2203, 1'b0},
      '{16'h2220, 1'b1}, '{16'h24A0, 1'b0}, '{16'h0202, 1'b0},
      '{16'h0480, 1'b0}, '{16'h0800, 1'b0}, '{16'h0103, 1'b1},
      '{16'h01E0, 1'b0}};
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   otp_eeprom_command_sequencer dut (.sys_clk, .reset, .ctrlWrite,
      .ctrlWord, .commandEndClear, .commandFailClear, .commandEndFlag,
      .commandFailFlag, .busy, .shadowAddr, .shadowRdEn, .shadowWrEn,
      .shadowWrData, .shadowRdData, .otpAddr, .otpRdEn, .otpProgEn,
      .otpProgData, .otpMargin, .otpFinalPulse, .otpRdData, .otpFinalIn,
      .eepromAddr, .eepromRdReq, .eepromAck, .eepromErr, .eepromRdData);
   nv_partner model (.sys_clk, .failReq, .shadowAddr, .shadowRdEn,
      .shadowWrEn, .shadowWrData, .shadowRdData, .otpAddr, .otpRdEn,
      .otpProgEn, .otpProgData, .otpFinalPulse, .otpRdData, .otpFinalIn,
      .eepromAddr, .eepromRdReq, .eepromAck, .eepromErr, .eepromRdData);
   // Tally strobes and margin levels seen at the memory ports
   always @(posedge sys_clk) begin
      if (otpProgEn === 1'b1) progCount++;
      if (otpFinalPulse === 1'b1) finalCount++;
      if (otpRdEn === 1'b1) marginSeen <= otpMargin;
      if (eepromRdReq === 1'b1 && otpMargin !== 2'h0) marginBad <= 1'b1;
   end
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   task automatic offer(input logic [15:0] w);
      @(posedge sys_clk);
      ctrlWrite <= 1'b1;
      ctrlWord <= w;
      @(posedge sys_clk);
      ctrlWrite <= 1'b0;
   endtask : offer
   // Issue, optionally intrude while busy, wait for the end, clear flags
   task automatic run(input logic [15:0] w, input logic expFail,
                      input logic [15:0] extra = 16'h0000);
      int k;
      offer(w);
      if (extra != 16'h0000) begin
         @(posedge sys_clk);
         `CHK("busy", 1'b1, busy)
         offer(extra);
      end
      k = 0;
      while (commandEndFlag !== 1'b1 && k < 2000) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 2000) begin
         n_errors++;
         close_out();
      end
      @(posedge sys_clk);
      `CHK("fail flag", expFail, commandFailFlag)
      commandEndClear <= 1'b1;
      commandFailClear <= 1'b1;
      @(posedge sys_clk);
      commandEndClear <= 1'b0;
      commandFailClear <= 1'b0;
   endtask : run
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      `CHK("reset outputs", 9'h000, {busy, commandEndFlag, commandFailFlag,
         shadowWrEn, otpProgEn, eepromRdReq, otpFinalPulse, otpMargin})
      // Table pass; the last row reloads pages 2 to 4 from the EEPROM
      foreach (rows[i]) run(rows[i].word, rows[i].fail);
      for (int a = 0; a < 40; a++) begin
         `CHK("shadow", (a < 16) ? 8'h40 + 8'(a) : 8'h80 + 8'(a),
            model.shadowMem[a])
      end
      `CHK("programmed words", 32, progCount)
      `CHK("margin on eeprom", 1'b0, marginBad)
      // Shadow page 3 now differs from the OTP copy
      p = progCount;
      run(16'h2203, 1'b0);
      `CHK("write pulses", p + 8, progCount)
      for (int a = 24; a < 32; a++) begin
         `CHK("otp word", 8'h80 + 8'(a), model.otpMem[a])
      end
      run(16'h2483, 1'b0);
      run(16'h2482, 1'b1);
      `CHK("margin on verify", 2'h2, marginSeen)
      run(16'h2102, 1'b0);
      run(16'h2482, 1'b0);
      // A bulk EEPROM read also fills shadow page 4
      model.shadowMem[32] = 8'h00;
      run(16'h0122, 1'b0);
      `CHK("eeprom page 4", 8'hA0, model.shadowMem[32])
      failReq <= 1'b1;
      run(16'h0121, 1'b1);
      failReq <= 1'b0;
      // A write offered while busy must leave no trace
      p = progCount;
      run(16'h2120, 1'b0, 16'h2202);
      repeat (10) @(posedge sys_clk);
      `CHK("no late end", 1'b0, commandEndFlag)
      `CHK("no late write", p, progCount)
      // No command bit, and two command bits, are both ignored
      foreach (rows[i]) if (i < 2) begin
         offer(i == 0 ? 16'h2000 : 16'h2300);
         repeat (10) @(posedge sys_clk);
         `CHK("ignored word", 1'b0, commandEndFlag)
      end
      run(16'h2802, 1'b0);
      `CHK("final pulses", 1, finalCount)
      p = progCount;
      run(16'h2203, 1'b1);
      `CHK("locked write", p, progCount)
      run(16'h2482, 1'b1);
      model.shadowMem[16] = model.shadowMem[16] | 8'h01;
      run(16'h2482, 1'b0);
      close_out();
   end
endmodule : test_otp_eeprom_command_sequencer
